// [core/ssd_adapter.sv]
`timescale 1ns/1ps
module ssd_adapter import ssd_pkg::*; (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic tx_clk,
  input wire logic bus_phase_two_clock,
  input wire logic tx_wr,
  input wire logic [7:0] tx_wdata,
  input wire logic stat_rd,
  input wire logic rx_data_rd,
  input wire logic rx_irq_enable,
  input wire logic tx_irq_enable,
  input wire logic error_irq_enable,
  input wire logic transmitter_reset_bit,
  input wire logic receiver_reset_bit,
  input wire logic underflow_clear_cmd,
  input wire logic cts_clear_cmd,
  input wire logic sync_on_underflow,
  input wire logic two_byte_mode,
  input wire logic ext_sync_mode,
  input wire logic [2:0] word_len,
  input wire logic [7:0] sync_code,
  input wire logic rx_stage2_full,
  input wire logic rx_stage3_full,
  input wire logic rx_overrun_evt,
  input wire logic rx_parity_evt,
  input wire logic dcd_pin,
  input wire logic cts_pin,
  output logic [7:0] adapter_status,
  output logic irq_n,
  output logic tx_serial,
  output logic tx_underflow
);
  typedef struct packed {
    logic dcd_s1;
    logic dcd_s2;
    logic dcd_q;
    logic cts_s1;
    logic cts_s2;
    logic cts_q;
    logic ack_s1;
    logic ack_s2;
    logic uf_s1;
    logic uf_s2;
    logic uf_q;
    logic txr_q;
    logic clr_pend;
    logic tx_hold;
    logic req_tgl;
    logic pend;
    logic stat_seen;
    logic dcd_lat;
    logic cts_lat;
    logic uf_lat;
    logic ovr_lat;
    logic par_lat;
    logic [7:0] status;
    logic irq_n;
  } ssd_main_t;

  localparam ssd_main_t SSD_MAIN_RST = '{
    tx_hold: 1'b1,
    status: SSD_STATUS_RST,
    irq_n: SSD_IRQ_N_RST,
    default: '0
  };

  ssd_main_t s;
  ssd_main_t next_s;

  logic [SSD_STAGES-1:0] fifo_full;
  logic [7:0] fifo_out;
  logic ack_tgl;
  logic uf_tgl;
  logic txr_rise;
  logic fifo_clear;
  logic pop;
  logic offer;
  logic dcd_rise;
  logic cts_rise;
  logic uf_evt;
  logic rx_pair_read;
  logic rx_avail;
  logic tx_space;
  logic irq;

  // Clear on the reset bit's rising edge, release on next phase-two pulse
  assign txr_rise = transmitter_reset_bit && !s.txr_q;
  assign fifo_clear = txr_rise || s.clr_pend;
  assign pop = s.pend && (s.ack_s2 == s.req_tgl);
  // The transmitter stays inhibited while the reset bit is held,
  // so preloaded characters wait in the buffer
  assign offer = !s.pend && fifo_full[SSD_STAGES-1] && !transmitter_reset_bit
                 && !fifo_clear;
  assign dcd_rise = s.dcd_s2 && !s.dcd_q;
  assign cts_rise = s.cts_s2 && !s.cts_q;
  // Transmitter sits in reset then, so a toggle is only its restart
  assign uf_evt = (s.uf_s2 ^ s.uf_q) && !transmitter_reset_bit;
  assign rx_pair_read = rx_data_rd && s.stat_seen;

  ssd_tx_fifo #(
    .W(SSD_DATA_W),
    .D(SSD_STAGES)
  ) u_fifo (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .clear(fifo_clear),
    .advance(bus_phase_two_clock),
    .wr_en(tx_wr),
    .wr_data(tx_wdata),
    .pop(pop && clk_en),
    .full(fifo_full),
    .out_data(fifo_out)
  );

  // Offered word stays put in the last stage until the ack comes back
  ssd_tx_shifter u_shifter (
    .tx_clk(tx_clk),
    .reset_req(s.tx_hold),
    .offer_tgl(s.req_tgl),
    .offer_data(fifo_out),
    .word_len(word_len),
    .sync_code(sync_code),
    .sync_on_underflow(sync_on_underflow),
    .ack_tgl(ack_tgl),
    .uf_tgl(uf_tgl),
    .tx_serial(tx_serial),
    .tx_underflow(tx_underflow)
  );

  always_comb begin
    next_s = s;
    rx_avail = 1'b0;
    tx_space = 1'b0;
    irq = 1'b0;
    if (clk_en) begin
      next_s.dcd_s1 = dcd_pin;
      next_s.dcd_s2 = s.dcd_s1;
      next_s.dcd_q = s.dcd_s2;
      next_s.cts_s1 = cts_pin;
      next_s.cts_s2 = s.cts_s1;
      next_s.cts_q = s.cts_s2;
      next_s.ack_s1 = ack_tgl;
      next_s.ack_s2 = s.ack_s1;
      next_s.uf_s1 = uf_tgl;
      next_s.uf_s2 = s.uf_s1;
      next_s.uf_q = s.uf_s2;
      next_s.txr_q = transmitter_reset_bit;
      next_s.tx_hold = transmitter_reset_bit;

      if (txr_rise) begin
        next_s.clr_pend = 1'b1;
      end else if (bus_phase_two_clock) begin
        next_s.clr_pend = 1'b0;
      end

      if (transmitter_reset_bit || pop) begin
        next_s.pend = 1'b0;
      end else if (offer) begin
        next_s.pend = 1'b1;
        next_s.req_tgl = ~s.req_tgl;
      end

      // Status read is only remembered, never clears anything itself
      if (stat_rd) begin
        next_s.stat_seen = 1'b1;
      end else if (rx_data_rd) begin
        next_s.stat_seen = 1'b0;
      end

      // Every latch: a set in the clearing cycle wins
      if (dcd_rise) begin
        next_s.dcd_lat = 1'b1;
      end else if (rx_pair_read || receiver_reset_bit) begin
        next_s.dcd_lat = 1'b0;
      end

      if (cts_rise) begin
        next_s.cts_lat = 1'b1;
      end else if (cts_clear_cmd || transmitter_reset_bit) begin
        next_s.cts_lat = 1'b0;
      end

      if (uf_evt) begin
        next_s.uf_lat = 1'b1;
      end else if (underflow_clear_cmd || transmitter_reset_bit) begin
        next_s.uf_lat = 1'b0;
      end

      if (rx_overrun_evt) begin
        next_s.ovr_lat = 1'b1;
      end else if (rx_pair_read || receiver_reset_bit) begin
        next_s.ovr_lat = 1'b0;
      end

      if (rx_parity_evt) begin
        next_s.par_lat = 1'b1;
      end else if (rx_data_rd || receiver_reset_bit) begin
        next_s.par_lat = 1'b0;
      end

      if (two_byte_mode) begin
        rx_avail = rx_stage2_full && rx_stage3_full;
      end else begin
        rx_avail = rx_stage3_full;
      end
      rx_avail = rx_avail && !receiver_reset_bit;

      if (two_byte_mode) begin
        tx_space = !fifo_full[0] && !fifo_full[1];
      end else begin
        tx_space = !fifo_full[0];
      end
      // Write drops the flag at once, not a cycle after the stage fills
      tx_space = tx_space && !tx_wr;
      tx_space = tx_space && !transmitter_reset_bit;
      // Inhibit only: the buffer keeps its contents
      tx_space = tx_space && !(s.cts_s2 && !ext_sync_mode);

      next_s.status[ST_RX_AVAIL] = rx_avail;
      next_s.status[ST_TX_SPACE] = tx_space;
      next_s.status[ST_DCD] = next_s.dcd_lat || s.dcd_s2;
      next_s.status[ST_CTS] = next_s.cts_lat || s.cts_s2;
      next_s.status[ST_UNDERFLOW] = next_s.uf_lat;
      next_s.status[ST_OVERRUN] = next_s.ovr_lat;
      next_s.status[ST_PARITY] = next_s.par_lat;

      irq = (rx_irq_enable && rx_avail) || (tx_irq_enable && tx_space);
      irq = irq || (error_irq_enable && (|next_s.status[ST_PARITY:ST_DCD]));
      next_s.status[ST_IRQ] = irq;
      next_s.irq_n = !irq;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s <= SSD_MAIN_RST;
    end else begin
      s <= next_s;
    end
  end

  assign adapter_status = s.status;
  assign irq_n = s.irq_n;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  property p_txr_inhibit;
    clk_en && transmitter_reset_bit |=> !adapter_status[ST_TX_SPACE];
  endproperty
  a_txr_inhibit: assert property (p_txr_inhibit)
    else $error("transmit space shown during transmitter reset");

  property p_wr_drops;
    clk_en && tx_wr |=> !adapter_status[ST_TX_SPACE];
  endproperty
  a_wr_drops: assert property (p_wr_drops)
    else $error("transmit space still set after buffer write");

  property p_cts_inhibit;
    clk_en && s.cts_s2 && !ext_sync_mode |=> !adapter_status[ST_TX_SPACE];
  endproperty
  a_cts_inhibit: assert property (p_cts_inhibit)
    else $error("clear-to-send did not inhibit transmit space");

  property p_two_byte_space;
    clk_en && two_byte_mode && fifo_full[1] |=> !adapter_status[ST_TX_SPACE];
  endproperty
  a_two_byte_space: assert property (p_two_byte_space)
    else $error("two-byte space shown with stage two full");

  property p_irq_mirror;
    adapter_status[ST_IRQ] == !irq_n;
  endproperty
  a_irq_mirror: assert property (p_irq_mirror)
    else $error("status bit 7 disagrees with interrupt output");

  property p_read_harmless;
    clk_en && stat_rd && s.uf_lat && !underflow_clear_cmd && !transmitter_reset_bit
      |=> adapter_status[ST_UNDERFLOW];
  endproperty
  a_read_harmless: assert property (p_read_harmless)
    else $error("status read disturbed underflow bit");

  property p_uf_clear;
    clk_en && underflow_clear_cmd && !uf_evt |=> !adapter_status[ST_UNDERFLOW];
  endproperty
  a_uf_clear: assert property (p_uf_clear)
    else $error("underflow bit survived its clear");

  property p_dcd_latch;
    clk_en && dcd_rise |=> adapter_status[ST_DCD];
  endproperty
  a_dcd_latch: assert property (p_dcd_latch)
    else $error("carrier rise not latched");

  property p_cts_latch;
    clk_en && cts_rise |=> adapter_status[ST_CTS];
  endproperty
  a_cts_latch: assert property (p_cts_latch)
    else $error("clear-to-send rise not latched");

  property p_ovr_clear;
    clk_en && receiver_reset_bit && !rx_overrun_evt |=> !adapter_status[ST_OVERRUN];
  endproperty
  a_ovr_clear: assert property (p_ovr_clear)
    else $error("overrun bit survived receiver reset");

  property p_par_clear;
    clk_en && rx_data_rd && !rx_parity_evt |=> !adapter_status[ST_PARITY];
  endproperty
  a_par_clear: assert property (p_par_clear)
    else $error("parity bit survived data read");

  property p_rx_avail;
    clk_en && two_byte_mode && !rx_stage2_full |=> !adapter_status[ST_RX_AVAIL];
  endproperty
  a_rx_avail: assert property (p_rx_avail)
    else $error("receive-available set with stage two empty");

  property p_no_enable_no_irq;
    clk_en && !error_irq_enable && !rx_irq_enable && !tx_irq_enable |=> irq_n;
  endproperty
  a_no_enable_no_irq: assert property (p_no_enable_no_irq)
    else $error("interrupt raised with all enables off");

  property p_rx_irq;
    clk_en && rx_irq_enable && rx_stage3_full && !two_byte_mode && !receiver_reset_bit
      |=> !irq_n;
  endproperty
  a_rx_irq: assert property (p_rx_irq)
    else $error("receive data did not raise interrupt");
endmodule : ssd_adapter

// [core/ssd_pkg.sv]
package ssd_pkg;
  localparam int SSD_DATA_W = 8;
  localparam int SSD_STAGES = 3;
  localparam int ST_RX_AVAIL = 0;
  localparam int ST_TX_SPACE = 1;
  localparam int ST_DCD = 2;
  localparam int ST_CTS = 3;
  localparam int ST_UNDERFLOW = 4;
  localparam int ST_OVERRUN = 5;
  localparam int ST_PARITY = 6;
  localparam int ST_IRQ = 7;
  localparam logic [7:0] SSD_STATUS_RST = 8'h00;
  localparam logic SSD_IRQ_N_RST = 1'b1;
  localparam logic [8:0] SSD_MARK_FRAME = 9'h1ff;

  function automatic logic [3:0] ssd_data_bits(input logic [2:0] wl);
    case (wl)
      3'h0, 3'h1: ssd_data_bits = 4'h6;
      3'h2, 3'h4, 3'h5: ssd_data_bits = 4'h7;
      default: ssd_data_bits = 4'h8;
    endcase
  endfunction : ssd_data_bits

  function automatic logic ssd_has_par(input logic [2:0] wl);
    ssd_has_par = (wl != 3'h2) && (wl != 3'h3);
  endfunction : ssd_has_par
endpackage : ssd_pkg

// [core/ssd_tx_fifo.sv]
`timescale 1ns/1ps
module ssd_tx_fifo import ssd_pkg::*; #(
  parameter int W = SSD_DATA_W,
  parameter int D = SSD_STAGES
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic clear,
  input wire logic advance,
  input wire logic wr_en,
  input wire logic [W-1:0] wr_data,
  input wire logic pop,
  output logic [D-1:0] full,
  output logic [W-1:0] out_data
);
  typedef struct packed {
    logic [D-1:0] full;
    logic [D-1:0][W-1:0] data;
  } ssd_fifo_t;

  ssd_fifo_t s;
  ssd_fifo_t next_s;

  always_comb begin
    next_s = s;
    if (clk_en) begin
      if (clear) begin
        next_s.full = '0;
      end else begin
        if (pop) begin
          next_s.full[D-1] = 1'b0;
        end
        // Downward walk lets a bubble collapse in one pulse
        for (int i = D - 1; i > 0; i--) begin
          if (advance && next_s.full[i-1] && !next_s.full[i]) begin
            next_s.data[i] = next_s.data[i-1];
            next_s.full[i] = 1'b1;
            next_s.full[i-1] = 1'b0;
          end
        end
        if (wr_en && !next_s.full[0]) begin
          next_s.data[0] = wr_data;
          next_s.full[0] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign full = s.full;
  assign out_data = s.data[D-1];

  property p_write_lands;
    @(posedge ref_clk) disable iff (sys_rst)
    clk_en && !clear && wr_en && !s.full[0] |=> s.full[0];
  endproperty
  a_write_lands: assert property (p_write_lands)
    else $error("write into empty first stage lost");
endmodule : ssd_tx_fifo

// [core/ssd_tx_shifter.sv]
`timescale 1ns/1ps
module ssd_tx_shifter import ssd_pkg::*; (
  input wire logic tx_clk,
  input wire logic reset_req,
  input wire logic offer_tgl,
  input wire logic [7:0] offer_data,
  input wire logic [2:0] word_len,
  input wire logic [7:0] sync_code,
  input wire logic sync_on_underflow,
  output logic ack_tgl,
  output logic uf_tgl,
  output logic tx_serial,
  output logic tx_underflow
);
  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic req_s1;
    logic req_s2;
    logic ack;
    logic uf;
    logic [8:0] sh;
    logic [3:0] cnt;
    logic txd;
    logic ufo;
  } ssd_shf_t;

  ssd_shf_t s;
  ssd_shf_t next_s;

  // Parity only for data, or for fill in the 9-bit format
  function automatic logic [8:0] frame(input logic [7:0] d, input logic [2:0] wl,
                                       input logic fill);
    logic [8:0] v;
    logic [3:0] nb;
    v = 9'h000;
    nb = ssd_data_bits(wl);
    for (int i = 0; i < 8; i++) begin
      if (i < nb || fill) begin
        v[i] = d[i];
      end
    end
    if (ssd_has_par(wl) && (!fill || nb == 4'h8)) begin
      v[nb] = (^v[7:0]) ^ wl[0];
    end
    frame = v;
  endfunction : frame

  always_comb begin
    logic [8:0] f;
    f = SSD_MARK_FRAME;
    next_s = s;
    next_s.rst_s1 = reset_req;
    next_s.rst_s2 = s.rst_s1;
    next_s.req_s1 = offer_tgl;
    next_s.req_s2 = s.req_s1;
    next_s.ufo = 1'b0;
    if (s.rst_s2) begin
      next_s.ack = s.req_s2;
      // Underflow toggle needs a known start; the bus side masks this edge
      next_s.uf = 1'b0;
      next_s.sh = SSD_MARK_FRAME;
      next_s.cnt = 4'h0;
      next_s.txd = 1'b1;
    end else if (s.cnt == 4'h0) begin
      if (s.req_s2 != s.ack) begin
        f = frame(offer_data, word_len, 1'b0);
        next_s.ack = ~s.ack;
      end else if (sync_on_underflow) begin
        f = frame(sync_code, word_len, 1'b1);
        next_s.uf = ~s.uf;
        next_s.ufo = 1'b1;
      end
      next_s.txd = f[0];
      next_s.sh = {1'b1, f[8:1]};
      next_s.cnt = 4'(ssd_data_bits(word_len) + 4'(ssd_has_par(word_len)) - 4'h1);
    end else begin
      next_s.txd = s.sh[0];
      next_s.sh = {1'b1, s.sh[8:1]};
      next_s.cnt = s.cnt - 4'h1;
    end
  end

  // Reset arrives through the two flops above, so no clock-free path
  always_ff @(posedge tx_clk) begin
    s <= next_s;
  end

  assign ack_tgl = s.ack;
  assign uf_tgl = s.uf;
  assign tx_serial = s.txd;
  assign tx_underflow = s.ufo;

  property p_uf_pulse;
    @(posedge tx_clk) disable iff (s.rst_s2)
    s.ufo |=> !s.ufo ##1 (s.uf == $past(s.uf, 1));
  endproperty
  a_uf_pulse: assert property (p_uf_pulse)
    else $error("underflow output wider than one tx clock");
endmodule : ssd_tx_shifter

// [tb/ssd_link_model.sv]
`timescale 1ns/1ps
module ssd_link_model (
  output logic tx_clk,
  input wire logic tx_serial,
  input wire logic tx_underflow,
  output int zeros,
  output int uf_pulses,
  output int uf_width
);
  int run = 0;
  int zq = 0;
  int upq = 0;
  int uwq = 0;
  assign zeros = zq;
  assign uf_pulses = upq;
  assign uf_width = uwq;
  initial begin
    tx_clk = 1'b0;
    // Odd offset keeps the link clock out of phase with ref_clk
    #7;
    forever #15 tx_clk = ~tx_clk;
  end
  // Modem samples the line on the rising transmit clock
  always @(posedge tx_clk) begin
    if (tx_serial === 1'b0)
      zq <= zq + 1;
    if (tx_underflow === 1'b1) begin
      run <= run + 1;
    end else begin
      if (run > uwq)
        uwq <= run;
      if (run > 0)
        upq <= upq + 1;
      run <= 0;
    end
  end
endmodule : ssd_link_model

// [tb/ssd_adapter_tb_top.sv]
`timescale 1ns/1ps
module ssd_adapter_tb_top;
  import ssd_pkg::*;
  localparam logic [6:0] WR = 7'h01, SR = 7'h02, DR = 7'h04, UC = 7'h08;
  localparam logic [6:0] CC = 7'h10, OV = 7'h20, PR = 7'h40;
  logic ref_clk, sys_rst, clk_en, tx_clk, bus_phase_two_clock, tx_wr, stat_rd, rx_data_rd;
  logic rx_irq_enable, tx_irq_enable, error_irq_enable, transmitter_reset_bit;
  logic receiver_reset_bit, underflow_clear_cmd, cts_clear_cmd, sync_on_underflow;
  logic two_byte_mode, ext_sync_mode, rx_stage2_full, rx_stage3_full, rx_overrun_evt;
  logic rx_parity_evt, dcd_pin, cts_pin, irq_n, tx_serial, tx_underflow, any;
  logic [2:0] word_len;
  logic [7:0] tx_wdata, sync_code, adapter_status, d1, d2;
  logic [7:0] pre [4] = '{8'hc1, 8'h3f, 8'h01, 8'h00};
  logic [17:0] exp_q [$];
  logic [17:0] e;
  logic [31:0] rv;
  int zeros, uf_pulses, uf_width, fails, check_count, z0, u0;

  ssd_adapter i_ssd_adapter (.ref_clk, .sys_rst, .clk_en, .tx_clk, .bus_phase_two_clock,
    .tx_wr, .tx_wdata, .stat_rd, .rx_data_rd, .rx_irq_enable, .tx_irq_enable,
    .error_irq_enable, .transmitter_reset_bit, .receiver_reset_bit, .underflow_clear_cmd,
    .cts_clear_cmd, .sync_on_underflow, .two_byte_mode, .ext_sync_mode, .word_len,
    .sync_code, .rx_stage2_full, .rx_stage3_full, .rx_overrun_evt, .rx_parity_evt,
    .dcd_pin, .cts_pin, .adapter_status, .irq_n, .tx_serial, .tx_underflow);
  ssd_link_model i_ssd_link_model (.tx_clk, .tx_serial, .tx_underflow, .zeros,
    .uf_pulses, .uf_width);

  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : cyc

  task automatic results();
    $display("checks=%0d fails=%0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    check_count++;
    if (seen !== want) begin
      fails++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : chk

  // Driver notes the expectation; the watcher below judges it
  task automatic note(input logic [8:0] m, input logic [8:0] v);
    exp_q.push_back({m, v});
    cyc(1);
  endtask : note

  always @(negedge ref_clk) begin
    #1;
    while (exp_q.size() > 0) begin
      e = exp_q.pop_front();
      chk(32'({irq_n, adapter_status} & e[17:9]), 32'(e[8:0]));
    end
  end

  // Trailing low cycle avoids two writes of a strobe in one time step
  task automatic pulse(input logic [6:0] k);
    {rx_parity_evt, rx_overrun_evt, cts_clear_cmd, underflow_clear_cmd, rx_data_rd,
      stat_rd, tx_wr} = k;
    cyc(1);
    {rx_parity_evt, rx_overrun_evt, cts_clear_cmd, underflow_clear_cmd, rx_data_rd,
      stat_rd, tx_wr} = 7'h00;
    cyc(1);
  endtask : pulse

  task automatic wait_st(input int b, input logic v);
    int k;
    k = 0;
    while (adapter_status[b] !== v && k < 500) begin
      cyc(1);
      k++;
    end
    if (k == 500) begin
      fails++;
      results();
    end
  endtask : wait_st

  task automatic wait_z(input int t);
    int k;
    k = 0;
    while (zeros < t && k < 2000) begin
      cyc(1);
      k++;
    end
    if (k == 2000) begin
      fails++;
      results();
    end
    cyc(60);
    chk(32'(zeros), 32'(t));
  endtask : wait_z

  function automatic int cz(input logic [7:0] d, input int n);
    cz = 0;
    for (int i = 0; i < n; i++)
      cz += (d[i] == 1'b0);
  endfunction : cz

  // Bus phase two strobe, one cycle in four
  initial begin
    bus_phase_two_clock = 1'b0;
    forever begin
      cyc(3);
      bus_phase_two_clock = 1'b1;
      cyc(1);
      bus_phase_two_clock = 1'b0;
    end
  end

  initial begin
    {sys_rst, clk_en} = 2'b11;
    {tx_wr, stat_rd, rx_data_rd, rx_irq_enable, tx_irq_enable, error_irq_enable} = 6'h00;
    {transmitter_reset_bit, receiver_reset_bit, underflow_clear_cmd, cts_clear_cmd} = 4'h0;
    {sync_on_underflow, two_byte_mode, ext_sync_mode, rx_stage2_full} = 4'h0;
    {rx_stage3_full, rx_overrun_evt, rx_parity_evt, dcd_pin, cts_pin} = 5'h00;
    {word_len, tx_wdata, sync_code} = {3'h3, 8'h00, 8'h00};
    fails = 0;
    check_count = 0;
    rv = $urandom(59310);
    cyc(20);
    sys_rst = 1'b0;
    cyc(3);
    note(9'h1ff, 9'h102);
    z0 = zeros;
    two_byte_mode = 1'b1;
    d1 = 8'($urandom);
    d2 = 8'($urandom);
    tx_wdata = d1;
    pulse(WR);
    note(9'h002, 9'h000);
    cyc(3);
    tx_wdata = d2;
    pulse(WR);
    wait_st(1, 1'b1);
    wait_z(z0 + cz(d1, 8) + cz(d2, 8));
    note(9'h010, 9'h000);
    two_byte_mode = 1'b0;
    cts_pin = 1'b1;
    cyc(5);
    note(9'h00a, 9'h008);
    ext_sync_mode = 1'b1;
    cyc(3);
    note(9'h002, 9'h002);
    cts_pin = 1'b0;
    cyc(5);
    note(9'h008, 9'h008);
    pulse(CC);
    cyc(1);
    note(9'h008, 9'h000);
    ext_sync_mode = 1'b0;
    transmitter_reset_bit = 1'b1;
    cyc(6);
    word_len = 3'h0;
    z0 = zeros;
    for (int i = 0; i < 4; i++) begin
      tx_wdata = pre[i];
      if (i < 3)
        z0 += cz(pre[i], 6) + (^pre[i][5:0] == 1'b0);
      pulse(WR);
      note(9'h002, 9'h000);
      cyc(4);
    end
    transmitter_reset_bit = 1'b0;
    wait_z(z0);
    transmitter_reset_bit = 1'b1;
    {word_len, sync_on_underflow, sync_code} = {3'h3, 1'b1, 8'h0f};
    cyc(4);
    transmitter_reset_bit = 1'b0;
    u0 = uf_pulses;
    wait_st(4, 1'b1);
    cyc(40);
    chk(32'(uf_pulses > u0), 32'h1);
    chk(32'(uf_width), 32'h1);
    transmitter_reset_bit = 1'b1;
    sync_on_underflow = 1'b0;
    pulse(UC);
    cyc(4);
    note(9'h012, 9'h000);
    dcd_pin = 1'b1;
    cyc(5);
    dcd_pin = 1'b0;
    pulse(OV | PR);
    cyc(4);
    note(9'h064, 9'h064);
    pulse(DR);
    note(9'h064, 9'h024);
    pulse(SR);
    note(9'h024, 9'h024);
    pulse(DR);
    note(9'h024, 9'h000);
    dcd_pin = 1'b1;
    pulse(PR | OV);
    cyc(5);
    dcd_pin = 1'b0;
    cyc(4);
    note(9'h064, 9'h064);
    receiver_reset_bit = 1'b1;
    cyc(3);
    note(9'h064, 9'h000);
    receiver_reset_bit = 1'b0;
    for (int i = 0; i < 8; i++) begin
      {two_byte_mode, rx_stage2_full, rx_stage3_full} = 3'(i);
      cyc(2);
      note(9'h001, 9'(i[2] ? i[1] & i[0] : i[0]));
    end
    two_byte_mode = 1'b0;
    for (int i = 0; i < 8; i++) begin
      rv = $urandom;
      rx_stage3_full = rv[0];
      {rx_irq_enable, tx_irq_enable, error_irq_enable} = 3'(i);
      if (rv[1])
        pulse(OV);
      cyc(2);
      any = (rv[0] & i[2]) | (rv[1] & i[0]);
      note(9'h1ff, {~any, any, 1'b0, rv[1], 4'h0, rv[0]});
      pulse(SR);
      pulse(DR);
    end
    // Frozen block must not latch a carrier rise
    clk_en = 1'b0;
    dcd_pin = 1'b1;
    cyc(5);
    note(9'h004, 9'h000);
    {clk_en, dcd_pin} = 2'b10;
    rx_stage3_full = 1'b0;
    {rx_irq_enable, tx_irq_enable, error_irq_enable} = 3'b010;
    transmitter_reset_bit = 1'b0;
    cyc(3);
    note(9'h182, 9'h082);
    tx_irq_enable = 1'b0;
    cyc(2);
    note(9'h180, 9'h100);
    cyc(2);
    results();
  end
endmodule : ssd_adapter_tb_top
